// >>> verilog/cmc_pkg.sv
/*
 Constants, register map and carrier types of the CAN mode control block.
 Assumes one 20 MHz clock shared by the block and the protocol core.
*/
package cmc_pkg;
    // Register offsets
    localparam logic [3:0] OFF_CTL0 = 4'h0;
    localparam logic [3:0] OFF_CTL1 = 4'h1;
    localparam logic [3:0] OFF_BTR0 = 4'h2;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFF_IRQ_EN = 4'h5;
    localparam logic [3:0] OFF_IRQ_CLR = 4'h6;
    localparam logic [3:0] OFF_RECOVER = 4'h7;
    // control_one fields
    localparam int B_ENABLE = 7;
    localparam int B_CLKSEL = 6;
    localparam int B_LOOP = 5;
    localparam int B_MONITOR = 4;
    localparam int B_BUSOFF_RECOVERY_SELECT = 3;
    localparam int B_WFILT = 2;
    localparam int B_SLEEP_ACK = 1;
    localparam int B_INIT_ACK = 0;
    localparam int CTL1_WR_LO = 2;
    // control_zero fields and the recovery request bit
    localparam int B_WAKE_EN = 2;
    localparam int B_SLEEP_REQ = 1;
    localparam int B_INIT_REQ = 0;
    localparam int B_REC_REQ = 0;
    // bit_timing_zero fields
    localparam int JW_HI = 7;
    localparam int JW_LO = 6;
    localparam int PRE_HI = 5;
    localparam int PRE_LO = 0;
    // Reset values
    localparam logic [7:0] CTL1_RESET = 8'h11;
    localparam logic [7:0] BTR0_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    // Interrupt event bits
    localparam int EV_TX = 0;
    localparam int EV_RX = 1;
    localparam int EV_WAKE = 2;
    localparam int EV_BOFF = 3;
    localparam int NUM_EV = 4;
    // Wake filter time
    localparam int CLK_PERIOD_NS = 50;
    localparam int WAKE_FILTER_NS = 2000;
    localparam int WAKE_FILTER_CYC = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic tx_bit;
        logic ack_drive;
        logic err_drive;
        logic bus_idle;
        logic tx_done;
        logic rx_done;
        logic busoff;
        logic recover_ok;
    } cmc_core_in_t;

    typedef struct packed {
        logic rx_bit;
        logic ack_ignore;
        logic tx_allow;
        logic err_freeze;
        logic recover_go;
        logic tq_tick;
        logic bus_clock;
        logic [2:0] jump_tq;
    } cmc_core_out_t;
endpackage

// >>> verilog/cmc_top.sv
/*
 CAN mode control, handshakes and first bit timing register.
 Assumes a protocol core on CLK behind CORE_IN/CORE_OUT and OSC_TICK
 already on CLK; only BUS_RECEIVE_PIN comes from outside the clock domain.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module cmc_top #(
    parameter int WAKE_CYC = cmc_pkg::WAKE_FILTER_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic CE,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic OSC_TICK,
    input wire logic BUS_RECEIVE_PIN,
    output logic BUS_TRANSMIT_PIN,
    input wire cmc_pkg::cmc_core_in_t CORE_IN,
    output cmc_pkg::cmc_core_out_t CORE_OUT,
    output logic IRQ
);
    localparam int WW = $clog2(WAKE_CYC + 1);
    localparam logic [WW-1:0] WAKE_MAX = WW'(WAKE_CYC);

    logic rx_s1, rx_s2, rx_s3, rx_lvl;
    logic [7:2] ctl1;
    logic [7:0] btr0;
    logic init_request, init_ack, sleep_request, sleep_ack, wake_enable;
    logic [3:0] irq_stat, irq_en;
    logic rec_pend, busoff_q;
    logic [WW-1:0] wake_cnt;
    logic [5:0] pre_cnt;

    // Decode
    wire wr_ctl0 = WR && ADDR == cmc_pkg::OFF_CTL0;
    wire wr_ctl1 = WR && ADDR == cmc_pkg::OFF_CTL1;
    wire wr_btr0 = WR && ADDR == cmc_pkg::OFF_BTR0;
    wire wr_en = WR && ADDR == cmc_pkg::OFF_IRQ_EN;
    wire wr_clr = WR && ADDR == cmc_pkg::OFF_IRQ_CLR;
    wire wr_rec = WR && ADDR == cmc_pkg::OFF_RECOVER;

    // Mode bits
    wire module_enable_bit = ctl1[cmc_pkg::B_ENABLE];
    wire clock_select = ctl1[cmc_pkg::B_CLKSEL];
    wire self_loopback = ctl1[cmc_pkg::B_LOOP];
    wire monitor_only = ctl1[cmc_pkg::B_MONITOR];
    wire busoff_recovery_select = ctl1[cmc_pkg::B_BUSOFF_RECOVERY_SELECT];
    wire wake_filter_select = ctl1[cmc_pkg::B_WFILT];
    wire [1:0] jump_width = btr0[cmc_pkg::JW_HI:cmc_pkg::JW_LO];
    wire [5:0] quantum_prescaler = btr0[cmc_pkg::PRE_HI:cmc_pkg::PRE_LO];

    wire init_active = init_request && init_ack;
    wire sleep_active = sleep_request && sleep_ack;
    wire run = module_enable_bit && !init_request && !sleep_active;

    // Wake detection
    wire wake_hit = wake_filter_select ? (wake_cnt == WAKE_MAX) : !rx_lvl;
    wire wake_seen = sleep_active && wake_enable && wake_hit;
    wire [WW-1:0] next_wake_cnt = (!sleep_active || rx_lvl) ? '0 :
        (wake_cnt == WAKE_MAX) ? wake_cnt : wake_cnt + WW'(1);

    // Control zero handshake requests and control one acknowledges
    wire wd_init = WDATA[cmc_pkg::B_INIT_REQ];
    wire wd_sleep = WDATA[cmc_pkg::B_SLEEP_REQ];
    wire next_init_request = !wr_ctl0 ? init_request :
        (wd_init || !init_ack) ? (wd_init || init_request) : 1'b0;
    wire sleep_set_ok = !irq_stat[cmc_pkg::EV_WAKE];
    wire next_sleep_request = wake_seen ? 1'b0 :
        !wr_ctl0 ? sleep_request :
        wd_sleep ? (sleep_request || sleep_set_ok) :
        (sleep_ack ? 1'b0 : sleep_request);
    wire next_init_ack = init_request;
    wire next_sleep_ack = wake_seen ? 1'b0 :
        !sleep_request ? 1'b0 :
        (CORE_IN.bus_idle && !init_request) ? 1'b1 : sleep_ack;

    // Events and interrupts
    wire [3:0] ev;
    assign ev[cmc_pkg::EV_TX] = run && CORE_IN.tx_done;
    assign ev[cmc_pkg::EV_RX] = run && (CORE_IN.rx_done || (self_loopback && CORE_IN.tx_done));
    assign ev[cmc_pkg::EV_WAKE] = wake_seen;
    assign ev[cmc_pkg::EV_BOFF] = CORE_IN.busoff && !busoff_q;
    wire [3:0] clr_mask = wr_clr ? WDATA[3:0] : 4'h0;
    wire [3:0] next_irq_stat = (irq_stat & ~clr_mask) | ev;

    // Bus-off recovery
    wire rec_set = wr_rec && WDATA[cmc_pkg::B_REC_REQ] && busoff_recovery_select;
    wire recover_go = run && CORE_IN.busoff && CORE_IN.recover_ok &&
        (!busoff_recovery_select || rec_pend);
    wire next_rec_pend = (rec_pend && !recover_go) || rec_set;

    // Time quantum prescaler
    wire pclk_tick = clock_select ? 1'b1 : OSC_TICK;
    wire pre_wrap = pre_cnt == quantum_prescaler;
    wire tq_pulse = run && pclk_tick && pre_wrap;
    wire [5:0] next_pre_cnt = !run ? 6'h00 : !pclk_tick ? pre_cnt :
        pre_wrap ? 6'h00 : pre_cnt + 6'h01;

    // Pin and core paths
    wire tx_line = CORE_IN.tx_bit && !CORE_IN.ack_drive && !CORE_IN.err_drive;
    wire drive_ok = run && !self_loopback && !monitor_only;
    wire next_tx_pin = drive_ok ? tx_line : 1'b1;
    wire next_rx_bit = !run ? 1'b1 : self_loopback ? CORE_IN.tx_bit : rx_lvl;
    cmc_pkg::cmc_core_out_t next_core;
    assign next_core.rx_bit = next_rx_bit;
    assign next_core.ack_ignore = self_loopback;
    assign next_core.tx_allow = run && !monitor_only;
    assign next_core.err_freeze = monitor_only;
    assign next_core.recover_go = recover_go;
    assign next_core.tq_tick = tq_pulse;
    assign next_core.bus_clock = clock_select;
    assign next_core.jump_tq = {1'b0, jump_width} + 3'h1;

    // Read mux
    wire [7:0] rd_ctl0 = {5'h00, wake_enable, sleep_request, init_request};
    wire [7:0] rd_ctl1 = {ctl1, sleep_ack, init_ack};
    wire [7:0] next_rdata = !RD ? 8'h00 :
        ADDR == cmc_pkg::OFF_CTL0 ? rd_ctl0 :
        ADDR == cmc_pkg::OFF_CTL1 ? rd_ctl1 :
        ADDR == cmc_pkg::OFF_BTR0 ? btr0 :
        ADDR == cmc_pkg::OFF_IRQ_STAT ? {4'h0, irq_stat} :
        ADDR == cmc_pkg::OFF_IRQ_EN ? {4'h0, irq_en} : 8'h00;

    // Receive pin synchroniser
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_lvl <= 1'b1;
        end else if (CE) begin
            rx_s1 <= BUS_RECEIVE_PIN;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_lvl <= rx_s3;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctl1 <= cmc_pkg::CTL1_RESET[7:2];
            btr0 <= cmc_pkg::BTR0_RESET;
            wake_enable <= 1'b0;
        end else if (CE) begin
            if (wr_ctl1 && init_active) begin
                ctl1 <= WDATA[7:2];
            end
            if (wr_btr0 && init_active) begin
                btr0 <= WDATA;
            end
            if (wr_ctl0) begin
                wake_enable <= WDATA[cmc_pkg::B_WAKE_EN];
            end
        end
    end

    // Handshakes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            init_request <= 1'b1;
            init_ack <= cmc_pkg::CTL1_RESET[cmc_pkg::B_INIT_ACK];
            sleep_request <= 1'b0;
            sleep_ack <= cmc_pkg::CTL1_RESET[cmc_pkg::B_SLEEP_ACK];
            wake_cnt <= '0;
        end else if (CE) begin
            init_request <= next_init_request;
            init_ack <= next_init_ack;
            sleep_request <= next_sleep_request;
            sleep_ack <= next_sleep_ack;
            wake_cnt <= next_wake_cnt;
        end
    end

    // Interrupts, recovery and prescaler
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_stat <= cmc_pkg::IRQ_RESET;
            irq_en <= cmc_pkg::IRQ_RESET;
            rec_pend <= 1'b0;
            busoff_q <= 1'b0;
            pre_cnt <= 6'h00;
        end else if (CE) begin
            irq_stat <= next_irq_stat;
            if (wr_en) begin
                irq_en <= WDATA[3:0];
            end
            rec_pend <= next_rec_pend;
            busoff_q <= CORE_IN.busoff;
            pre_cnt <= next_pre_cnt;
        end
    end

    // Outputs
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 8'h00;
            BUS_TRANSMIT_PIN <= 1'b1;
            CORE_OUT <= '0;
            IRQ <= 1'b0;
        end else if (CE) begin
            RDATA <= next_rdata;
            BUS_TRANSMIT_PIN <= next_tx_pin;
            CORE_OUT <= next_core;
            IRQ <= |(next_irq_stat & irq_en);
        end
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    a_disable_gate: assert property (CE && !module_enable_bit |=>
        BUS_TRANSMIT_PIN && !CORE_OUT.tq_tick && !CORE_OUT.tx_allow)
        else $error("disabled block still active");
    a_clock_select: assert property (CE && !clock_select && !OSC_TICK |=>
        !CORE_OUT.tq_tick) else $error("quantum tick without oscillator tick");
    a_loop_pin: assert property (CE && self_loopback |=>
        BUS_TRANSMIT_PIN && (CORE_OUT.rx_bit == ($past(run) ? $past(CORE_IN.tx_bit) : 1'b1)))
        else $error("loopback path wrong");
    a_loop_irqs: assert property (CE && run && self_loopback && CORE_IN.tx_done |=>
        irq_stat[cmc_pkg::EV_TX] && irq_stat[cmc_pkg::EV_RX] && CORE_OUT.ack_ignore)
        else $error("loopback frame missed an interrupt");
    a_monitor_quiet: assert property (CE && monitor_only |=>
        BUS_TRANSMIT_PIN && !CORE_OUT.tx_allow && CORE_OUT.err_freeze)
        else $error("monitor mode drove the bus");

    a_recover_req: assert property (busoff_recovery_select && !rec_pend |->
        !recover_go) else $error("recovery without request");

    a_wake_any: assert property (CE && sleep_active && wake_enable &&
        !wake_filter_select && !rx_lvl |=> !sleep_ack && !sleep_request)
        else $error("dominant level did not wake");

    a_init_ack: assert property (CE && init_request && !init_ack |=> init_ack)
        else $error("init acknowledge late");

    a_ctl1_lock: assert property (CE && wr_ctl1 && !init_active |=>
        $stable(ctl1)) else $error("control written outside init");

    a_btr0_lock: assert property (CE && wr_btr0 && !init_active |=>
        $stable(btr0)) else $error("timing written outside init");

    a_jump_width: assert property (CE |=>
        CORE_OUT.jump_tq == {1'b0, $past(jump_width)} + 3'h1)
        else $error("jump width wrong");

    a_tq_spacing: assert property (CE && tq_pulse && quantum_prescaler != 6'h00 |=>
        ##1 (!CORE_OUT.tq_tick || !$past(CE))) else $error("quanta too close");

    a_ack_readonly: assert property (CE && wr_ctl1 && !init_request |=>
        !init_ack) else $error("acknowledge taken from write");

    a_sleep_drop: assert property (CE && !sleep_request |=>
        !sleep_ack)
        else $error("sleep acknowledge without request");

    a_sleep_enter: assert property (CE && sleep_request && CORE_IN.bus_idle &&
        !init_request && !sleep_ack |=> sleep_ack)
        else $error("sleep not entered on idle bus");

    a_wake_filter: assert property (CE && sleep_active && wake_enable &&
        wake_filter_select && wake_cnt != WAKE_MAX && !wr_ctl0 |=> sleep_ack)
        else $error("short pulse woke the block");

    a_wake_flag: assert property (CE && wake_seen |=>
        irq_stat[cmc_pkg::EV_WAKE] && !sleep_request)
        else $error("wake not flagged");

    a_wake_off: assert property (CE && sleep_active && !wake_enable && !wr_ctl0 |=>
        sleep_ack)
        else $error("woke with wake disabled");

    a_init_hold: assert property (CE && wr_ctl0 && !WDATA[cmc_pkg::B_INIT_REQ] &&
        init_request && !init_ack |=> init_request)
        else $error("init request cleared before acknowledge");

    a_init_drop: assert property (CE && !init_request |=>
        !init_ack)
        else $error("init acknowledge without request");

    a_ctl1_write: assert property (CE && wr_ctl1 && init_active |=>
        ctl1 == $past(WDATA[7:2]))
        else $error("control write lost in init");

    a_btr0_write: assert property (CE && wr_btr0 && init_active |=>
        btr0 == $past(WDATA))
        else $error("timing write lost in init");

    a_tx_drive: assert property (CE && run && !self_loopback && !monitor_only |=>
        BUS_TRANSMIT_PIN == $past(tx_line))
        else $error("transmit pin not driven");

    a_rx_path: assert property (CE && run && !self_loopback |=>
        CORE_OUT.rx_bit == $past(rx_lvl))
        else $error("receive path wrong");

    a_monitor_ack: assert property (CE && monitor_only && CORE_IN.ack_drive |=>
        BUS_TRANSMIT_PIN)
        else $error("monitor mode drove acknowledge");

    a_irq_level: assert property (CE && !wr_en |=>
        IRQ == |(irq_stat & irq_en))
        else $error("interrupt level wrong");

    a_status_sticky: assert property (CE && irq_stat[cmc_pkg::EV_TX] &&
        !(wr_clr && WDATA[cmc_pkg::EV_TX]) |=> irq_stat[cmc_pkg::EV_TX])
        else $error("status bit lost");

    a_auto_recover: assert property (CE && run && !busoff_recovery_select &&
        CORE_IN.busoff && CORE_IN.recover_ok |=> CORE_OUT.recover_go)
        else $error("automatic recovery missing");

    a_rec_clear: assert property (CE && recover_go && !rec_set |=>
        !rec_pend)
        else $error("recovery request not consumed");

    a_tq_off: assert property (CE && !run |=>
        !CORE_OUT.tq_tick && pre_cnt == 6'h00)
        else $error("prescaler runs while stopped");

    a_bus_clock: assert property (CE |=>
        CORE_OUT.bus_clock == $past(clock_select))
        else $error("clock source flag wrong");

    a_loop_ack: assert property (CE && self_loopback |=>
        CORE_OUT.ack_ignore)
        else $error("loopback acknowledge not ignored");
endmodule

// >>> sim/cmc_partner.sv
/*
 Bus model: transceiver and remote nodes as one wired-AND line.
 Assumes the bench commands when a remote node holds the bus dominant.
*/
`timescale 1ns/1ps
module cmc_partner (
    input wire logic tx_pin,
    input wire logic remote_dom,
    output logic rx_pin
);
    // Dominant wins; recessive only when every node releases
    assign rx_pin = tx_pin & ~remote_dom;
endmodule

// >>> sim/cmc_top_test.sv
/*
 Self-checking bench for the CAN mode control block.
 Assumes CE always high and a short wake filter of 4 cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module cmc_top_test;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic OSC = 1'b0;
    logic remote_dom = 1'b0;
    logic [7:0] RDATA;
    logic tx_pin;
    logic rx_pin;
    logic IRQ;
    cmc_pkg::cmc_core_in_t ci = 8'h11;
    cmc_pkg::cmc_core_out_t co;
    int mismatches = 0;
    int n_checks = 0;
    always #25 CLK = ~CLK;
    cmc_top #(.WAKE_CYC(4)) cmc_top_inst (.CLK(CLK), .SRST(SRST), .CE(1'b1), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OSC_TICK(OSC),
        .BUS_RECEIVE_PIN(rx_pin), .BUS_TRANSMIT_PIN(tx_pin), .CORE_IN(ci),
        .CORE_OUT(co), .IRQ(IRQ));
    cmc_partner cmc_partner_inst (.tx_pin(tx_pin), .remote_dom(remote_dom), .rx_pin(rx_pin));
    task automatic wt(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        `CHK(nm, e, RDATA)
    endtask
    // Enter init, load control and timing, clear status, leave init
    task automatic cfg(input logic [7:0] c1, input logic [7:0] b0);
        wr(4'h0, 8'h01);
        wr(4'h1, c1);
        wr(4'h2, b0);
        wr(4'h6, 8'h0f);
        wr(4'h0, 8'h00);
        wt(3);
    endtask
    task automatic pulse(input int which);
        @(posedge CLK);
        if (which == 0) ci.tx_done <= 1'b1; else ci.rx_done <= 1'b1;
        @(posedge CLK);
        ci.tx_done <= 1'b0;
        ci.rx_done <= 1'b0;
        wt(3);
    endtask
    task automatic cnt(input int cyc, input int sel, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge CLK);
            #1;
            if ((sel == 0 ? co.tq_tick : co.recover_go) === 1'b1) n++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #(50 * 6000);
        mismatches++;
        end_sim();
    end
    initial begin
        int n;
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        rc(4'h1, 8'h11, "ctl1 reset");
        rc(4'h2, 8'h00, "btr0 reset");
        wr(4'h1, 8'hff);
        wr(4'h2, 8'hc5);
        rc(4'h1, 8'hfd, "ctl1 ack bits");
        rc(4'h2, 8'hc5, "btr0 rw");
        wt(2);
        `CHK("jump", 3'h4, co.jump_tq)
        `CHK("bus clock", 1'b1, co.bus_clock)
        $display("test reset_regs end");
        cfg(8'hc0, 8'h02);
        cnt(30, 0, n);
        `CHK("tq ticks", 10, n)
        wr(4'h2, 8'h3f);
        rc(4'h2, 8'h02, "btr0 locked");
        ci.tx_bit <= 1'b0;
        wt(3);
        `CHK("tx pin normal", 1'b0, tx_pin)
        `CHK("tx allow", 1'b1, co.tx_allow)
        ci.tx_bit <= 1'b1;
        wr(4'h5, 8'h01);
        pulse(1);
        `CHK("irq masked", 1'b0, IRQ)
        pulse(0);
        `CHK("irq set", 1'b1, IRQ)
        wr(4'h6, 8'h01);
        wt(2);
        `CHK("irq clear", 1'b0, IRQ)
        $display("test normal end");
        cfg(8'h80, 8'h01);
        cnt(12, 0, n);
        `CHK("osc idle", 0, n)
        OSC <= 1'b1;
        wt(1);
        cnt(12, 0, n);
        `CHK("osc ticks", 6, n)
        OSC <= 1'b0;
        cfg(8'h40, 8'h00);
        ci.tx_bit <= 1'b0;
        wt(3);
        `CHK("tx pin off", 1'b1, tx_pin)
        pulse(0);
        rc(4'h4, 8'h00, "status off");
        $display("test disabled end");
        cfg(8'he0, 8'h00);
        ci.tx_bit <= 1'b0;
        wt(3);
        `CHK("tx pin loop", 1'b1, tx_pin)
        `CHK("loop rx", 1'b0, co.rx_bit)
        `CHK("ack ignore", 1'b1, co.ack_ignore)
        ci.tx_bit <= 1'b1;
        remote_dom <= 1'b1;
        wt(8);
        `CHK("loop rx pin", 1'b1, co.rx_bit)
        remote_dom <= 1'b0;
        pulse(0);
        rc(4'h4, 8'h03, "loop events");
        $display("test loopback end");
        cfg(8'hd0, 8'h00);
        ci.tx_bit <= 1'b0;
        ci.ack_drive <= 1'b1;
        wt(3);
        `CHK("tx pin monitor", 1'b1, tx_pin)
        `CHK("freeze", 1'b1, co.err_freeze)
        `CHK("no tx", 1'b0, co.tx_allow)
        ci.tx_bit <= 1'b1;
        ci.ack_drive <= 1'b0;
        $display("test monitor end");
        cfg(8'hc8, 8'h00);
        ci.busoff <= 1'b1;
        ci.recover_ok <= 1'b1;
        cnt(8, 1, n);
        `CHK("no auto recover", 0, n)
        wr(4'h7, 8'h01);
        cnt(6, 1, n);
        `CHK("recover on request", 1'b1, n != 0)
        cfg(8'hc0, 8'h00);
        cnt(8, 1, n);
        `CHK("auto recover", 1'b1, n != 0)
        ci.busoff <= 1'b0;
        $display("test recovery end");
        cfg(8'hc0, 8'h00);
        wr(4'h0, 8'h06);
        wt(3);
        rc(4'h1, 8'hc2, "sleep ack");
        remote_dom <= 1'b1;
        wt(10);
        remote_dom <= 1'b0;
        rc(4'h1, 8'hc0, "woken");
        rc(4'h0, 8'h04, "sleep req cleared");
        rc(4'h4, 8'h04, "wake status");
        cfg(8'hc4, 8'h00);
        wr(4'h0, 8'h06);
        wt(3);
        remote_dom <= 1'b1;
        wt(2);
        remote_dom <= 1'b0;
        wt(10);
        rc(4'h1, 8'hc6, "short pulse");
        remote_dom <= 1'b1;
        wt(12);
        remote_dom <= 1'b0;
        wt(2);
        rc(4'h1, 8'hc4, "long pulse");
        $display("test sleep end");
        end_sim();
    end
endmodule
